/* hw/cpg_pkg.sv */
`default_nettype none
package cpg_pkg;
  // Register indices; byte address is index times four
  localparam logic [5:0] IDX_SYSCLK = 6'h00;
  localparam logic [5:0] IDX_LOWPWR = 6'h01;
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned ADR_LSB = 2;
  // System clock control fields
  localparam int unsigned B_CLK_STOP = 7;
  localparam int unsigned B_SW_MODE = 3;
  localparam int unsigned BSEL_W = 3;
  localparam logic [7:0] SYSCLK_WMASK = 8'h8F;
  localparam logic [7:0] SYSCLK_RST = 8'h00;
  // Low-power control fields
  localparam logic [7:0] LOWPWR_WMASK = 8'h0F;
  localparam logic [7:0] LOWPWR_RST = 8'h00;
  localparam int unsigned FACT_W = 2;
  // Factor codes
  localparam logic [1:0] F_X1 = 2'h0;
  localparam logic [1:0] F_X2 = 2'h1;
  localparam logic [1:0] F_X4 = 2'h2;
  localparam logic [1:0] F_BAD = 2'h3;
  // Bus clock select codes
  localparam logic [2:0] BSEL_HIGH = 3'h0;
  localparam logic [2:0] BSEL_MAX = 3'h5;
  // Medium-speed divider counter
  localparam int unsigned DIV_W = 5;
  localparam logic [4:0] DIV_ALL = 5'h1F;
  // Reference period counter and settling counter widths
  localparam int unsigned PER_W = 12;
  localparam logic [11:0] PER_MAX = 12'hFFF;
  localparam int unsigned SETTLE_W = 24;
  localparam int unsigned SETTLE_BASE = 1024;
  localparam int unsigned WAIT_W = 3;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_SWSTBY,
    MODE_SETTLE
  } cpg_mode_e;
endpackage : cpg_pkg
`default_nettype wire

/* hw/cpg_mdiv.sv */
`timescale 1ns/1ps
`default_nettype none
module cpg_mdiv (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic phi_tick,
  input wire logic [cpg_pkg::BSEL_W-1:0] sel_in,
  output logic bus_en
);
  import cpg_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [BSEL_W-1:0] sel_q;
  logic [DIV_W-1:0] mask;
  logic wrap;

  // Ones in the low bits for the division; prohibited codes run full speed
  function automatic logic [DIV_W-1:0] div_mask(input logic [BSEL_W-1:0] s);
    if (s > BSEL_MAX) begin
      return '0;
    end
    return DIV_W'((1 << s) - 1);
  endfunction : div_mask

  assign mask = div_mask(sel_q);
  assign wrap = phi_tick && (cnt_q == DIV_ALL);

  // Free count of phi ticks
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (phi_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // R15 select on boundary
  // Taken only at the /32 wrap, so every division starts on a whole period
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_q <= BSEL_HIGH;
    end else if (wrap) begin
      sel_q <= sel_in;
    end
  end

  // R05 bus clock divide
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_en <= 1'b0;
    end else begin
      bus_en <= phi_tick && ((cnt_q & mask) == mask);
    end
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sel_on_wrap: assert property ( // R15
    !$stable(sel_q) |-> $past(wrap)) else $error("bus select changed off boundary");
  a_high_speed: assert property ( // R05
    sel_q == BSEL_HIGH && phi_tick |=> bus_en) else $error("full speed tick lost");
  a_div_gap: assert property ( // R05
    sel_q == 3'h1 && phi_tick && !cnt_q[0] |=> !bus_en) else $error("div2 too fast");
endmodule : cpg_mdiv
`default_nettype wire

/* hw/cpg_ctrl.sv */
// Behaviour
// R01 - Clock out pin follows phi unless stop bit set; high in software standby; floats in hw standby.
// R02 - Bits 6 to 4 of the system clock control register always read as zero.
// R03 - With deferred mode, a new factor waits until software standby is entered.
// R04 - With immediate mode, a new factor takes effect right after the factor bits are written.
// R05 - Bus clock select 000 is full speed, 001 to 101 divide by 2 to 32, 11X prohibited.
// R06 - Factor code 00 is x1, 01 is x2, 10 is x4, 11 is prohibited for software.
// R07 - Software writes only zeros to bits 7 to 4 of the low-power control register.
// R08 - Bits 3 and 2 of the low-power control register are read/write; software keeps them 0.
// R09 - The rising edge of the internal clock is aligned to the reference input rising edge.
// R10 - After reset the active multiplication factor is x1.
// R11 - In deferred mode, entering software standby halts the generator and loads the factor.
// R12 - Leaving software standby counts the selected settling time, then runs at the new factor.
// R13 - A break armed on sleep still enters standby and is signalled after settling.
// R14 - Software picks a settling wait of at least 20 us, even with an external clock.
// R15 - Bus clock and immediate factor switches happen on clock boundaries only.
`timescale 1ns/1ps
`default_nettype none
module cpg_ctrl #(
  parameter int unsigned SETTLE_BASE_P = cpg_pkg::SETTLE_BASE
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cpg_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic osc_input_pin,
  input wire logic hw_standby_pin,
  input wire logic sleep_req,
  input wire logic standby_sel,
  input wire logic [cpg_pkg::WAIT_W-1:0] standby_wait_select,
  input wire logic wake_req,
  input wire logic break_armed,
  output logic sys_clk_en,
  output logic bus_clk_en,
  output logic clk_out_o,
  output logic clk_out_oe,
  output logic break_take
);
  import cpg_pkg::*;

  logic [2:0] osc_sync_q;
  logic [2:0] hws_sync_q;
  logic osc_lvl_q;
  logic hws_lvl_q;
  logic osc_edge;
  logic [7:0] sysclk_q;
  logic [7:0] lowpwr_q;
  logic [FACT_W-1:0] active_q;
  logic [FACT_W-1:0] fact_new;
  logic pend_q;
  logic req;
  logic wr;
  logic lp_wr;
  logic [5:0] idx;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] per_q;
  logic [PER_W-1:0] seg_len;
  logic [PER_W-1:0] cnt_q;
  logic [3:0] half_q;
  logic phi_q;
  logic halt;
  cpg_mode_e mode_q;
  logic [SETTLE_W-1:0] settle_q;
  logic brk_arm_q;
  logic enter_stby;

  // Prohibited factor code falls back to x1
  // R06 factor decode
  function automatic logic [FACT_W-1:0] eff_factor(input logic [FACT_W-1:0] c);
    return (c == F_BAD) ? F_X1 : c;
  endfunction : eff_factor

  // Half periods of phi per reference period: 2, 4 or 8
  function automatic logic [3:0] last_half(input logic [FACT_W-1:0] f);
    return 4'((2 << f) - 1);
  endfunction : last_half

  // Pins from outside pass three stages; a level counts once stages 2 and 3 agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_sync_q <= '0;
      hws_sync_q <= '0;
      osc_lvl_q <= 1'b0;
      hws_lvl_q <= 1'b0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], osc_input_pin};
      hws_sync_q <= {hws_sync_q[1:0], hw_standby_pin};
      if (osc_sync_q[2] == osc_sync_q[1]) begin
        osc_lvl_q <= osc_sync_q[1];
      end
      if (hws_sync_q[2] == hws_sync_q[1]) begin
        hws_lvl_q <= hws_sync_q[1];
      end
    end
  end

  assign osc_edge = osc_sync_q[2] == osc_sync_q[1] && osc_sync_q[1] && !osc_lvl_q;

  // Bus decode; unmapped indices are acked and read zero
  assign idx = wb_adr_i[ADR_LSB +: 6];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign lp_wr = wr && idx == IDX_LOWPWR;
  assign fact_new = eff_factor(lowpwr_q[FACT_W-1:0]);
  assign halt = mode_q == MODE_SWSTBY || mode_q == MODE_SETTLE || hws_lvl_q;
  assign enter_stby = mode_q == MODE_RUN && sleep_req && standby_sel && !hws_lvl_q;

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Register writes land on the same edge that raises ack
  // R02 reserved bits dropped
  // R08 low bits stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sysclk_q <= SYSCLK_RST;
      lowpwr_q <= LOWPWR_RST;
    end else if (wr) begin
      if (idx == IDX_SYSCLK) begin
        sysclk_q <= wb_dat_i[7:0] & SYSCLK_WMASK;
      end
      if (idx == IDX_LOWPWR) begin
        lowpwr_q <= wb_dat_i[7:0] & LOWPWR_WMASK;
      end
    end
  end

  // Read data registered with ack; narrow data in the low byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      unique case (idx)
        IDX_SYSCLK: wb_dat_o <= {24'h0, sysclk_q};
        IDX_LOWPWR: wb_dat_o <= {24'h0, lowpwr_q};
        IDX_STATUS: wb_dat_o <= {26'h0, mode_q == MODE_SETTLE, mode_q == MODE_SWSTBY,
                                 mode_q == MODE_SLEEP, pend_q, active_q};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // R04 immediate request
  // A write in the edge cycle stays pending for the next edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else if (lp_wr && sysclk_q[B_SW_MODE]) begin
      pend_q <= 1'b1;
    end else if (osc_edge) begin
      pend_q <= 1'b0;
    end
  end

  // R10 reset to x1
  // R11 load on standby entry
  // R15 immediate switch only at a reference edge, where phi restarts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_q <= F_X1;
    end else if (enter_stby && !sysclk_q[B_SW_MODE]) begin
      active_q <= fact_new;
    end else if (pend_q && osc_edge) begin
      active_q <= fact_new;
    end
  end

  // Reference period in system cycles; the count saturates at PER_MAX, and a saturated count stores a period of zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      per_cnt_q <= '0;
      per_q <= '0;
    end else if (osc_edge) begin
      per_cnt_q <= '0;
      per_q <= per_cnt_q + 1'b1;
    end else if (per_cnt_q != PER_MAX) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // Length of one half period of phi; a reference of 4096 cycles or more gives zero, and phi then stays high
  assign seg_len = per_q >> (active_q + 1'b1);

  // R09 phase aligned phi
  // Rising edge forced at each reference edge; halves fill the period between
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phi_q <= 1'b0;
      cnt_q <= '0;
      half_q <= '0;
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= 1'b0;
      if (halt) begin
        phi_q <= 1'b0;
        cnt_q <= '0;
        half_q <= '0;
      end else if (osc_edge) begin
        phi_q <= 1'b1;
        cnt_q <= '0;
        half_q <= '0;
        sys_clk_en <= 1'b1;
      end else if (seg_len != '0 && half_q < last_half(active_q)) begin
        if (cnt_q == seg_len - 1'b1) begin
          phi_q <= !phi_q;
          sys_clk_en <= !phi_q;
          cnt_q <= '0;
          half_q <= half_q + 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // Operating mode sequence
  // R12 settle then run
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= MODE_RUN;
    end else begin
      unique case (mode_q)
        MODE_RUN: begin
          if (sleep_req && !hws_lvl_q) begin
            mode_q <= standby_sel ? MODE_SWSTBY : MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (wake_req) begin
            mode_q <= MODE_RUN;
          end
        end
        MODE_SWSTBY: begin
          if (wake_req) begin
            mode_q <= MODE_SETTLE;
          end
        end
        MODE_SETTLE: begin
          if (settle_q == '0) begin
            mode_q <= MODE_RUN;
          end
        end
      endcase
    end
  end

  // R12 settling count
  // Length is base shifted by the wait select, loaded as the wake is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settle_q <= '0;
    end else if (mode_q == MODE_SWSTBY && wake_req) begin
      settle_q <= SETTLE_W'((SETTLE_BASE_P << standby_wait_select) - 1);
    end else if (mode_q == MODE_SETTLE && settle_q != '0) begin
      settle_q <= settle_q - 1'b1;
    end
  end

  // R13 break after settling
  // Standby is entered anyway; the break is raised when the clock is back
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      brk_arm_q <= 1'b0;
      break_take <= 1'b0;
    end else begin
      break_take <= 1'b0;
      if (enter_stby) begin
        brk_arm_q <= break_armed;
      end else if (mode_q == MODE_SETTLE && settle_q == '0) begin
        brk_arm_q <= 1'b0;
        break_take <= brk_arm_q;
      end
    end
  end

  // R01 clock out pin
  // Sleep with stop clear keeps phi running on the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_out_o <= 1'b1;
      clk_out_oe <= 1'b0;
    end else begin
      clk_out_oe <= !hws_lvl_q;
      unique case (mode_q)
        MODE_RUN, MODE_SLEEP: clk_out_o <= sysclk_q[B_CLK_STOP] | phi_q;
        MODE_SWSTBY, MODE_SETTLE: clk_out_o <= 1'b1;
      endcase
    end
  end

  // R05 medium speed divider
  cpg_mdiv u_mdiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .phi_tick(sys_clk_en),
    .sel_in(sysclk_q[BSEL_W-1:0]),
    .bus_en(bus_clk_en)
  );

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_stby_wake;
    mode_q == MODE_SWSTBY && wake_req;
  endsequence

  sequence s_settle_done;
    mode_q == MODE_SETTLE && settle_q == '0;
  endsequence

  a_stop_high: assert property ( // R01
    mode_q == MODE_RUN && sysclk_q[B_CLK_STOP] |=> clk_out_o)
    else $error("clock out not held high");
  a_stby_high: assert property ( // R01
    mode_q == MODE_SWSTBY |=> clk_out_o && !sys_clk_en)
    else $error("clock runs in standby");
  a_hws_float: assert property ( // R01
    hws_lvl_q |=> !clk_out_oe) else $error("pin driven in hw standby");
  a_rsv_zero: assert property ( // R02
    wb_ack_o && !wb_we_i && idx == IDX_SYSCLK |-> wb_dat_o[6:4] == 3'h0)
    else $error("reserved bits read nonzero");
  a_defer_hold: assert property ( // R03
    !pend_q && !enter_stby |=> $stable(active_q)) else $error("factor changed early");
  a_imm_apply: assert property ( // R04
    pend_q && osc_edge && !enter_stby |=> active_q == $past(fact_new))
    else $error("immediate factor not applied");
  a_lp_store: assert property ( // R08
    lp_wr |=> lowpwr_q[3:2] == $past(wb_dat_i[3:2]) && lowpwr_q[7:4] == 4'h0)
    else $error("low-power bits not stored");
  a_phi_align: assert property ( // R09
    osc_edge && !halt |=> phi_q && sys_clk_en) else $error("phi not aligned");
  a_reset_x1: assert property (@(posedge sys_clk) disable iff (1'b0) // R10
    rst |=> active_q == F_X1) else $error("factor not x1 after reset");
  a_stby_load: assert property ( // R11
    enter_stby && !sysclk_q[B_SW_MODE] |=> mode_q == MODE_SWSTBY
      && active_q == $past(fact_new)) else $error("factor not loaded in standby");
  a_settle_run: assert property ( // R12
    s_stby_wake ##1 mode_q == MODE_SETTLE |-> settle_q != '0 || SETTLE_BASE_P == 1)
    else $error("settle count not loaded");
  a_settle_end: assert property ( // R12
    s_settle_done |=> mode_q == MODE_RUN) else $error("settle did not end");
  a_break_take: assert property ( // R13
    s_settle_done ##0 brk_arm_q |=> break_take) else $error("break lost");
endmodule : cpg_ctrl
`default_nettype wire

/* tb/test_cpg_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_cpg_ctrl;
  import cpg_pkg::*;
  localparam int BASE = 256;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, osc = 1'b0, hws = 1'b0;
  logic slp = 1'b0, ssel = 1'b0, wake = 1'b0, brk = 1'b0, cko_d = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [WAIT_W-1:0] wsel = 3'h0;
  logic [4:0] oc = 5'h00;
  logic [31:0] rdat;
  logic ack, phi_en, bus_en, cko, cko_oe, btake;
  int bad_count = 0, num_checks = 0, cycles = 0, n_phi = 0, n_bus = 0, n_cko = 0;
  logic [31:0] exp_q[$];

  // Settling base lets a 20 us wait fit a short run; select 3 gives 2048 cycles
  cpg_ctrl #(.SETTLE_BASE_P(BASE)) u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .osc_input_pin(osc), .hw_standby_pin(hws),
    .sleep_req(slp), .standby_sel(ssel), .standby_wait_select(wsel), .wake_req(wake),
    .break_armed(brk), .sys_clk_en(phi_en), .bus_clk_en(bus_en), .clk_out_o(cko),
    .clk_out_oe(cko_oe), .break_take(btake));

  // System clock
  always #5 sys_clk = ~sys_clk;

  // Reference clock, 32 cycles a period so x4 resolves
  always @(posedge sys_clk) begin
    oc <= oc + 5'h01;
    osc <= oc[4];
  end

  // Pulse counters and hang guard; nonblocking so tasks see stable values
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (phi_en === 1'b1) n_phi <= n_phi + 1;
    if (bus_en === 1'b1) n_bus <= n_bus + 1;
    if (cko === 1'b1 && cko_d === 1'b0) n_cko <= n_cko + 1;
    cko_d <= cko;
    if (cycles > 40000) begin
      bad_count++;
      close_out();
    end
  end

  // Read data monitor takes the oldest expected note
  always @(posedge sys_clk) begin
    if (ack === 1'b1 && we === 1'b0) cmp(exp_q.pop_front(), rdat);
  end

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  // Classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd(input logic [5:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, idx, 8'h00);
  endtask : rd

  // Count pulses over a window; a negative bus or pin count means not checked
  task automatic win(input int c, input int ep, input int eb, input int ec);
    int p, b, k;
    p = n_phi;
    b = n_bus;
    k = n_cko;
    repeat (c) @(posedge sys_clk);
    cmp(ep, n_phi - p);
    if (eb >= 0) cmp(eb, n_bus - b);
    if (ec >= 0) cmp(ec, n_cko - k);
  endtask : win

  task automatic pulse(input bit s);
    @(posedge sys_clk);
    if (s) slp <= 1'b1;
    else wake <= 1'b1;
    @(posedge sys_clk);
    slp <= 1'b0;
    wake <= 1'b0;
  endtask : pulse

  task automatic close_out();
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial begin
    int ws, t, v, len;
    void'($urandom(32'hd0c83412));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(IDX_SYSCLK, 32'h0);
    rd(IDX_LOWPWR, 32'h0);
    rd(IDX_STATUS, 32'h0);
    v = $urandom_range(255);
    wb(1'b1, IDX_SYSCLK, v[7:0]);
    rd(IDX_SYSCLK, {24'h0, v[7:0] & SYSCLK_WMASK});
    wb(1'b1, IDX_SYSCLK, 8'h00);
    wb(1'b1, IDX_LOWPWR, 8'h0C);
    rd(IDX_LOWPWR, 32'h0C);
    wb(1'b1, IDX_LOWPWR, 8'h00);
    rd(6'h3F, 32'h0);
    win(256, 8, -1, 8);
    wb(1'b1, IDX_SYSCLK, 8'h80);
    // Let the pin settle high before counting rises
    repeat (2) @(posedge sys_clk);
    win(256, 8, -1, 0);
    cmp(32'h1, {31'h0, cko});
    wb(1'b1, IDX_SYSCLK, 8'h08);
    wb(1'b1, IDX_LOWPWR, {6'h00, F_X4});
    repeat (80) @(posedge sys_clk);
    win(256, 32, -1, 32);
    rd(IDX_STATUS, {30'h0, F_X4});
    wb(1'b1, IDX_SYSCLK, 8'h88);
    ssel <= 1'b0;
    pulse(1'b1);
    rd(IDX_STATUS, {28'h0, 4'h8} | F_X4);
    win(256, 32, -1, 0);
    pulse(1'b0);
    // Bus clock divide for every code; prohibited codes run full speed
    for (int n = 0; n < 8; n++) begin
      wb(1'b1, IDX_SYSCLK, 8'h08 | n[7:0]);
      repeat (320) @(posedge sys_clk);
      win(512, 64, (n < 6) ? (64 >> n) : 64, -1);
    end
    wb(1'b1, IDX_SYSCLK, 8'h00);
    wb(1'b1, IDX_LOWPWR, {6'h00, F_X2});
    rd(IDX_STATUS, {30'h0, F_X4});
    win(256, 32, -1, -1);
    // wait of 20 us or more
    ws = 3 + $urandom_range(1);
    wsel <= ws[2:0];
    ssel <= 1'b1;
    brk <= 1'b1;
    pulse(1'b1);
    rd(IDX_STATUS, {24'h0, 4'h1, 2'b00, F_X2});
    win(128, 0, -1, 0);
    cmp(32'h1, {31'h0, cko});
    pulse(1'b0);
    t = 0;
    len = BASE << ws;
    while (btake !== 1'b1) begin
      @(posedge sys_clk);
      t++;
    end
    cmp(32'h1, {31'h0, (t >= len - 1 && t <= len + 3)});
    repeat (80) @(posedge sys_clk);
    win(256, 16, -1, 16);
    hws <= 1'b1;
    repeat (10) @(posedge sys_clk);
    cmp(32'h0, {31'h0, cko_oe});
    win(128, 0, -1, -1);
    hws <= 1'b0;
    repeat (10) @(posedge sys_clk);
    cmp(32'h1, {31'h0, cko_oe});
    close_out();
  end
endmodule : test_cpg_ctrl
`default_nettype wire
